// [adcseq_defines.vh]
// Purpose: constants for the conversion sequencer
// Assumes: 100 MHz mclk is the device oscillator
// Notes: definitions only
`ifndef ADCSEQ_DEFINES_VH
`define ADCSEQ_DEFINES_VH
`define ADCSEQ_CCP_SPECIAL   4'hB
`define ADCSEQ_CLK_DIV2      2'h0
`define ADCSEQ_CLK_DIV8      2'h1
`define ADCSEQ_CLK_DIV32     2'h2
`define ADCSEQ_CLK_RC        2'h3
`define ADCSEQ_TOSC_2        6'h02
`define ADCSEQ_TOSC_8        6'h08
`define ADCSEQ_TOSC_32       6'h20
`define ADCSEQ_CONV_PERIODS  4'hD
`define ADCSEQ_DONE_PERIOD   4'hE
`define ADCSEQ_RESULT_BITS   12
`define ADCSEQ_QPH_Q2        2'h1
`define ADCSEQ_INSTR_QUARTERS 3'h4
`endif

// [adcseq_period_gen.v]
// Purpose: conversion bit period tick generator
// Assumes: rc_tick is already synchronised to mclk
// Notes: half tick marks the falling edge of a period
`include "adcseq_defines.vh"
`default_nettype none
module adcseq_period_gen (
    // Clock and reset
    input  wire       mclk,
    input  wire       reset_n,
    // Control
    input  wire       run,
    input  wire [1:0] conv_clock_select,
    input  wire       rc_tick,
    // Ticks
    output reg        rise_tick,
    output reg        fall_tick
);
    reg  [5:0] cnt_q;
    reg        rc_phase_q;
    reg  [5:0] len;

    always @* begin
        case (conv_clock_select)
            `ADCSEQ_CLK_DIV2:  len = `ADCSEQ_TOSC_2;
            `ADCSEQ_CLK_DIV8:  len = `ADCSEQ_TOSC_8;
            default:           len = `ADCSEQ_TOSC_32;
        endcase
    end

    // RC clock: rising half then falling half per rc edge pair
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q      <= 6'h00;
            rc_phase_q <= 1'b0;
            rise_tick  <= 1'b0;
            fall_tick  <= 1'b0;
        end else if (!run) begin
            cnt_q      <= 6'h00;
            rc_phase_q <= 1'b0;
            rise_tick  <= 1'b0;
            fall_tick  <= 1'b0;
        end else if (conv_clock_select == `ADCSEQ_CLK_RC) begin
            rise_tick <= rc_tick & ~rc_phase_q;
            fall_tick <= rc_tick & rc_phase_q;
            if (rc_tick)
                rc_phase_q <= ~rc_phase_q;
        end else begin
            rise_tick <= (cnt_q == 6'h00);
            fall_tick <= (cnt_q == (len >> 1));
            if (cnt_q == len - 6'h01)
                cnt_q <= 6'h00;
            else
                cnt_q <= cnt_q + 6'h01;
        end
    end
endmodule // adcseq_period_gen
`default_nettype wire

// [adcseq_sequencer.v]
// Purpose: start, stop and finish of analog conversions
// Assumes: comparator result arrives one bit per period, msb first
// Notes: result bytes have no reset, they survive warm resets
// What this block does
// - Special event starts conversion only with mode 1011b and converter on.
// - Special event sets go flag on second quarter phase and clears timer.
// - Converter off ignores special event, but timer still clears.
// - Reset restores control state, turns converter off, aborts conversion.
// - Non power-on reset leaves both result bytes unchanged.
// - Result bytes undefined after power-on; no initialisation needed.
// - Sampling period length does not depend on kept bit count.
// - Clearing go flag mid conversion stops it, unresolved bits zero.
// - With RC clock, wait one instruction cycle before converting.
// - Completion clears go flag and loads both result bytes.
// - Sleep completion wakes device when conversion interrupt enabled.
// - Interrupt disabled: stay asleep, converter on stays set.
// - Non-RC clock: sleep aborts conversion, powers down, on bit kept.
// - Thirteen bit periods; done flag on 14th rise, go clears on fall.
// - Clock select 00,01,10 give 2,8,32 oscillator periods; 11 is RC.
`include "adcseq_defines.vh"
`default_nettype none
module adcseq_sequencer (
    // Clock and reset
    input  wire        mclk,
    input  wire        reset_n,
    // Software control
    input  wire        converter_on_wr,
    input  wire        converter_on_in,
    input  wire        go_set,
    input  wire        go_clear,
    input  wire [1:0]  conv_clock_select,
    input  wire        done_flag_clear,
    input  wire        conv_int_enable,
    input  wire        sleep_req,
    // Trigger unit
    input  wire        special_event,
    input  wire [3:0]  capture_compare_mode_field,
    // Analog side, pins from outside
    input  wire        rc_clk_pin,
    input  wire        comparator_pin,
    // Status
    output reg         converter_on,
    output reg         convert_go_flag,
    output reg         conversion_done_flag,
    output reg         converter_powered,
    output reg         timer_clear,
    output reg         wake_req,
    output reg         sampling,
    output reg  [1:0]  quarter_phase,
    output reg  [7:0]  result_high_byte,
    output reg  [7:0]  result_low_byte
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_WAIT = 2'h1;
    localparam [1:0] ST_CONV = 2'h2;

    reg  [1:0]  state_q;
    reg  [3:0]  period_q;
    reg  [2:0]  wait_q;
    reg  [11:0] sar_q;
    reg         asleep_q;
    reg         rc_s1_q, rc_s2_q, rc_s3_q;
    reg         cmp_s1_q, cmp_s2_q;
    reg         evt_pend_q;
    wire        rc_tick;
    wire        rise_tick;
    wire        fall_tick;
    wire        rc_sel;
    wire        trig_ok;
    wire        abort_sleep;

    assign rc_sel      = (conv_clock_select == `ADCSEQ_CLK_RC);
    assign trig_ok     = converter_on &&
                         (capture_compare_mode_field == `ADCSEQ_CCP_SPECIAL);
    assign abort_sleep = asleep_q && !rc_sel;
    assign rc_tick     = rc_s2_q ^ rc_s3_q;

    // Pin synchronisers, first stage read only by second
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rc_s1_q  <= 1'b0;
            rc_s2_q  <= 1'b0;
            rc_s3_q  <= 1'b0;
            cmp_s1_q <= 1'b0;
            cmp_s2_q <= 1'b0;
        end else begin
            rc_s1_q  <= rc_clk_pin;
            rc_s2_q  <= rc_s1_q;
            rc_s3_q  <= rc_s2_q;
            cmp_s1_q <= comparator_pin;
            cmp_s2_q <= cmp_s1_q;
        end
    end

    adcseq_period_gen u_period (
        .mclk              (mclk),
        .reset_n           (reset_n),
        .run               (state_q == ST_CONV),
        .conv_clock_select (conv_clock_select),
        .rc_tick           (rc_tick),
        .rise_tick         (rise_tick),
        .fall_tick         (fall_tick)
    );

    // Quarter phase counter, one oscillator period each
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            quarter_phase <= 2'h0;
        else
            quarter_phase <= quarter_phase + 2'h1;
    end

    // Timer clear is not gated by converter_on
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            timer_clear <= 1'b0;
        else
            timer_clear <= special_event;
    end

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            converter_on         <= 1'b0;
            convert_go_flag      <= 1'b0;
            conversion_done_flag <= 1'b0;
            converter_powered    <= 1'b0;
            wake_req             <= 1'b0;
            sampling             <= 1'b0;
            asleep_q             <= 1'b0;
            evt_pend_q           <= 1'b0;
            state_q              <= ST_IDLE;
            period_q             <= 4'h0;
            wait_q               <= 3'h0;
            sar_q                <= 12'h000;
        end else begin
            // Wake request is a one-cycle pulse
            wake_req <= 1'b0;
            if (converter_on_wr)
                converter_on <= converter_on_in;
            if (sleep_req)
                asleep_q <= 1'b1;
            else if (wake_req)
                asleep_q <= 1'b0;
            // Non-RC sleep powers the analog part down, on bit kept
            converter_powered <= converter_on && !abort_sleep;
            // Sampling runs whenever converter is on and idle
            sampling <= converter_on && (state_q == ST_IDLE);
            // Hold trigger until the second quarter phase
            if (special_event && trig_ok)
                evt_pend_q <= 1'b1;
            if (evt_pend_q && quarter_phase == `ADCSEQ_QPH_Q2) begin
                evt_pend_q      <= 1'b0;
                convert_go_flag <= 1'b1;
            end else if (go_set && converter_on && !converter_on_wr) begin
                // Setting on and go together leaves go unset
                convert_go_flag <= 1'b1;
            end
            if (done_flag_clear)
                conversion_done_flag <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    // A same-cycle software clear must not start a run
                    if (convert_go_flag && converter_on && !abort_sleep && !go_clear) begin
                        sar_q    <= 12'h000;
                        period_q <= 4'h0;
                        wait_q   <= 3'h0;
                        state_q  <= rc_sel ? ST_WAIT : ST_CONV;
                    end
                end
                ST_WAIT: begin
                    // Lets the sleep instruction run before converting
                    wait_q <= wait_q + 3'h1;
                    if (wait_q == `ADCSEQ_INSTR_QUARTERS - 3'h1)
                        state_q <= ST_CONV;
                    if (go_clear || abort_sleep)
                        state_q <= ST_IDLE;
                end
                ST_CONV: begin
                    if (rise_tick) begin
                        period_q <= period_q + 4'h1;
                        if (period_q >= 4'h1 && period_q < `ADCSEQ_CONV_PERIODS)
                            sar_q[4'hC - period_q] <= cmp_s2_q;
                        if (period_q == `ADCSEQ_CONV_PERIODS) begin
                            conversion_done_flag <= 1'b1;
                            if (asleep_q && conv_int_enable)
                                wake_req <= 1'b1;
                        end
                    end
                    if (fall_tick && period_q == `ADCSEQ_DONE_PERIOD) begin
                        convert_go_flag <= 1'b0;
                        state_q         <= ST_IDLE;
                    end
                    if (go_clear || abort_sleep) begin
                        // Unresolved bits stay zero from the start clear
                        convert_go_flag <= 1'b0;
                        state_q         <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
            // Clear or sleep abort in any state, so go never sticks
            if (go_clear || abort_sleep)
                convert_go_flag <= 1'b0;
        end
    end

    // No reset: contents survive warm resets
    always @(posedge mclk) begin
        if (state_q == ST_CONV &&
            ((fall_tick && period_q == `ADCSEQ_DONE_PERIOD) || go_clear)) begin
            result_high_byte <= {4'h0, sar_q[11:8]};
            result_low_byte  <= sar_q[7:0];
        end
    end
endmodule // adcseq_sequencer
`default_nettype wire

// [adcseq_seq_properties.sv]
// Purpose: timing relations of the conversion sequencer
// Assumes: single mclk domain
// Notes: bound to adcseq_sequencer below
`include "adcseq_defines.vh"
`default_nettype none
module adcseq_seq_properties (
    // Clock and reset
    input wire logic       mclk,
    input wire logic       reset_n,
    // Requests
    input wire logic       go_set,
    input wire logic       go_clear,
    input wire logic       sleep_req,
    input wire logic       special_event,
    input wire logic [1:0] conv_clock_select,
    input wire logic [3:0] capture_compare_mode_field,
    // Status
    input wire logic       converter_on,
    input wire logic       convert_go_flag,
    input wire logic       conversion_done_flag,
    input wire logic       converter_powered,
    input wire logic       timer_clear,
    input wire logic       sampling,
    input wire logic [1:0] quarter_phase,
    input wire logic [7:0] result_high_byte,
    input wire logic [7:0] result_low_byte
);
    logic loaded_q;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // Result bytes hold X until the first load
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) loaded_q <= 1'b0;
        else if ($fell(convert_go_flag)) loaded_q <= 1'b1;
    end
    a_special_starts: assert property (special_event && converter_on && !go_clear
        && capture_compare_mode_field == `ADCSEQ_CCP_SPECIAL |-> ##[1:5] convert_go_flag)
        else $error("special event did not start a conversion");
    a_special_ignored: assert property (special_event && !converter_on
        && !convert_go_flag |=> !convert_go_flag [*5]) else $error("trigger started while off");
    a_timer_clear: assert property (special_event |=> timer_clear)
        else $error("timer not cleared by trigger");
    a_go_on_q2: assert property ($rose(convert_go_flag) && !$past(go_set)
        |-> $past(quarter_phase) == `ADCSEQ_QPH_Q2) else $error("trigger go off phase");
    a_done_then_clear: assert property ($rose(conversion_done_flag)
        |-> convert_go_flag ##[1:40] !convert_go_flag) else $error("go not cleared after done");
    a_abort_stops: assert property (go_clear && convert_go_flag |=> !convert_go_flag)
        else $error("abort ignored");
    a_results_hold: assert property (loaded_q && !$fell(convert_go_flag)
        |-> $stable({result_high_byte, result_low_byte})) else $error("result changed");
    a_high_zero: assert property (loaded_q |-> result_high_byte[7:4] == 4'h0)
        else $error("high nibble not zero");
    a_sleep_abort: assert property (sleep_req && convert_go_flag
        && conv_clock_select != `ADCSEQ_CLK_RC |-> ##[1:3] (!convert_go_flag
        && !converter_powered && converter_on)) else $error("sleep did not abort");
    a_sampling_idle: assert property (converter_on && !convert_go_flag |=> sampling)
        else $error("not sampling while idle");
    a_sampling_off: assert property (!converter_on |=> !sampling)
        else $error("sampling while converter off");
endmodule // adcseq_seq_properties
bind adcseq_sequencer adcseq_seq_properties chk_u (.mclk(mclk), .reset_n(reset_n),
    .go_set(go_set), .go_clear(go_clear), .sleep_req(sleep_req),
    .special_event(special_event), .conv_clock_select(conv_clock_select),
    .capture_compare_mode_field(capture_compare_mode_field), .converter_on(converter_on),
    .convert_go_flag(convert_go_flag), .conversion_done_flag(conversion_done_flag),
    .converter_powered(converter_powered), .timer_clear(timer_clear), .sampling(sampling),
    .quarter_phase(quarter_phase), .result_high_byte(result_high_byte),
    .result_low_byte(result_low_byte));
`default_nettype wire

// [adcseq_analog_model.sv]
// Purpose: comparator and RC oscillator facing the sequencer
// Assumes: bench picks the comparator level per conversion
// Notes: RC clock stands still while no conversion runs
`default_nettype none
module adcseq_analog_model (
    // From sequencer and bench
    input  wire logic convert_go_flag,
    input  wire logic level,
    // Analog pins
    output var logic  rc_clk_pin,
    output wire logic comparator_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rc_clk_pin = 1'b0;
    // Odd half period keeps edges off the mclk grid
    always begin
        wait (convert_go_flag);
        #35.3 rc_clk_pin = ~rc_clk_pin;
    end
    // Idle level is inverted so a stale sample cannot pass
    assign comparator_pin = convert_go_flag ? level : ~level;
endmodule // adcseq_analog_model
`default_nettype wire

// [tb_top.sv]
// Purpose: self-checking bench for adcseq_sequencer
// Assumes: 100 MHz mclk, RC bit period about 7 mclk
// Notes: strobe bits 0 on,1 go,2 clear,3 done clear,4 sleep,5 trigger
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, reset_n, on_in, int_en, lvl;
    logic [5:0] stb;
    logic [1:0] sel;
    logic [3:0] mode;
    logic [15:0] last;
    wire rc, cmp, on, go, done, pwr, tclr, wake;
    wire [7:0] rh, rl;
    int fail_count, num_checks, tc_n, wk_n, cyc, n, k;
    adcseq_sequencer dut_u (.mclk(mclk), .reset_n(reset_n), .converter_on_wr(stb[0]),
        .converter_on_in(on_in), .go_set(stb[1]), .go_clear(stb[2]),
        .conv_clock_select(sel), .done_flag_clear(stb[3]), .conv_int_enable(int_en),
        .sleep_req(stb[4]), .special_event(stb[5]), .capture_compare_mode_field(mode),
        .rc_clk_pin(rc), .comparator_pin(cmp), .converter_on(on), .convert_go_flag(go),
        .conversion_done_flag(done), .converter_powered(pwr), .timer_clear(tclr),
        .wake_req(wake), .sampling(), .quarter_phase(), .result_high_byte(rh),
        .result_low_byte(rl));
    adcseq_analog_model ana_u (.convert_go_flag(go), .level(lvl), .rc_clk_pin(rc),
        .comparator_pin(cmp));
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        if (tclr === 1'b1) tc_n++;
        if (wake === 1'b1) wk_n++;
    end
    function logic [15:0] exp_res(input logic b, input int nb);
        return {4'h0, b ? (12'hFFF << (12 - nb)) : 12'h000};
    endfunction
    function int per(input logic [1:0] s);
        return s == 2'h0 ? 2 : s == 2'h1 ? 8 : s == 2'h2 ? 32 : 7;
    endfunction
    task tick(input int c);
        repeat (c) @(posedge mclk);
        #1;
    endtask
    task strobe(input logic [5:0] v);
        @(posedge mclk);
        #1 stb = v;
        @(posedge mclk);
        #1 stb = 6'h00;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task give_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task wait_go();
        cyc = 0;
        while (go !== 1'b0 && cyc < 3000) begin
            tick(1);
            cyc++;
        end
        if (cyc >= 3000) begin
            fail_count++;
            give_verdict();
        end
    endtask
    task do_reset();
        reset_n = 1'b0;
        tick(2);
        chk({12'h0, on, go, done, pwr}, 16'h0);
        reset_n = 1'b1;
    endtask
    initial begin
        mclk = 0; reset_n = 0; stb = 0; on_in = 1; int_en = 0; lvl = 0;
        sel = 0; mode = 4'hB; fail_count = 0; num_checks = 0; tc_n = 0; wk_n = 0;
        void'($urandom(66));
        do_reset();
        strobe(6'h01);
        for (k = 0; k < 4; k++) begin
            sel = 2'(k);
            lvl = 1'($urandom % 2);
            strobe(6'h02);
            wait_go();
            chk({15'h0, cyc >= 13 * per(sel) && cyc <= 14 * per(sel) + 12}, 16'h1);
            chk({rh, rl}, exp_res(lvl, 12));
            chk({15'h0, done}, 16'h1);
            strobe(6'h08);
        end
        last = {rh, rl};
        $display("test full conversions done");
        strobe(6'h02);
        tick(30);
        do_reset();
        chk({rh, rl}, last);
        strobe(6'h01);
        $display("test warm reset done");
        sel = 2'h0;
        lvl = 1'b0;
        k = tc_n;
        strobe(6'h20);
        tick(6);
        chk({15'h0, go}, 16'h1);
        wait_go();
        mode = 4'($urandom % 11);
        strobe(6'h20);
        tick(6);
        chk({15'h0, go}, 16'h0);
        on_in = 0;
        mode = 4'hB;
        strobe(6'h01);
        strobe(6'h20);
        tick(6);
        chk({15'h0, go}, 16'h0);
        chk(16'(tc_n - k), 16'h3);
        on_in = 1;
        strobe(6'h01);
        $display("test trigger done");
        sel = 2'h2;
        lvl = 1;
        n = 1 + $urandom % 11;
        tick(4);
        strobe(6'h02);
        tick((n + 1) * 32 - 8);
        strobe(6'h04);
        tick(2);
        chk({rh, rl}, exp_res(1'b1, n));
        $display("test truncated conversion done");
        sel = 2'h3;
        int_en = 1;
        k = wk_n;
        strobe(6'h02);
        strobe(6'h10);
        wait_go();
        tick(3);
        chk(16'(wk_n - k), 16'h1);
        int_en = 0;
        strobe(6'h02);
        strobe(6'h10);
        wait_go();
        tick(3);
        chk({15'h0, on}, 16'h1);
        chk(16'(wk_n - k), 16'h1);
        do_reset();
        strobe(6'h01);
        $display("test rc sleep done");
        sel = 2'h1;
        strobe(6'h02);
        tick(20);
        strobe(6'h10);
        tick(4);
        chk({13'h0, go, on, pwr}, 16'h2);
        $display("test sleep abort done");
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
